// file: common/tspl_pkg.sv
// constants and types shared by the transport-stream link block
// Overview of operation
// - bytes and flags launch and are taken on the byte clock rising edge.
// - byte clock never exceeds 13,5 MHz; hand-over supports that rate, the serializer takes one byte per 16 system clocks.
// - parallel link is clock, eight data bits, payload-valid and start flags.
// - serial bit rate is set by the system clock, one half-cell per clock, not by the byte rate.
// - packets go back to back or with a 16-byte gap after each.
// - no justification bits are inserted or expected.
// - transmit path serializes aligned bytes and applies Biphase Mark coding.
// - receive path recovers data, decodes it, then hunts the sync word.
// - one transmitter to one receiver, one direction, no return channel.
// - data bit 7 is the MSB and the serializer sends it first.
package tspl_pkg;

  localparam logic [7:0] SYNC_BYTE      = 8'h47;
  localparam int         PKT_LEN_SHORT  = 188;
  localparam int         GAP_BYTES      = 16;
  localparam int         PKT_LEN_LONG   = PKT_LEN_SHORT + GAP_BYTES;
  localparam int         BITS_PER_BYTE  = 8;
  localparam int         HALF_PER_BYTE  = 2 * BITS_PER_BYTE;
  // byte clock ceiling in kHz and system clock period in ps
  localparam int         BYTE_CLK_MAX_KHZ = 13500;
  localparam int         CLK_PERIOD_PS    = 10000;
  // shortest byte period in system clocks, rounded up
  localparam int         BYTE_PERIOD_MIN_CYC =
    (1000000000 / BYTE_CLK_MAX_KHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         SYNC_MISS_LIMIT = 3;
  localparam logic [7:0] BYTE_RST       = 8'h00;
  localparam logic       LINE_RST       = 1'b0;

  typedef enum logic [1:0] {
    TSPL_HUNT,
    TSPL_CONFIRM,
    TSPL_LOCKED
  } tspl_align_t;

endpackage

// file: common/tspl_xfer_if.sv
// byte hand-over from the byte clock domain to the system clock domain
`timescale 1ns/100ps
interface tspl_xfer_if;
  logic [7:0] data;
  logic       payloadValidFlag;
  logic       packetStartFlag;
  logic       toggle;

  modport cap  (output data, output payloadValidFlag,
                output packetStartFlag, output toggle);
  modport core (input data, input payloadValidFlag,
                input packetStartFlag, input toggle);
endinterface

// file: hw/tspl_byte_capture.sv
// byte clock domain capture of the parallel transmit port
`timescale 1ns/100ps
module tspl_byte_capture (
  input  wire logic       byteClk,
  input  wire logic       rst,
  input  wire logic [7:0] byteIn,
  input  wire logic       payloadValidFlag,
  input  wire logic       packetStartFlag,
  tspl_xfer_if.cap        xfer
);
  import tspl_pkg::*;

  logic       rstS1_reg;
  logic       rstS2_reg;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       valid_reg;
  logic       valid_next;
  logic       start_reg;
  logic       start_next;
  logic       toggle_reg;
  logic       toggle_next;

  // reset is brought onto the byte clock before use
  always_ff @(posedge byteClk) begin
    rstS1_reg <= rst;
    rstS2_reg <= rstS1_reg;
  end

  always_comb begin
    data_next   = byteIn;
    valid_next  = payloadValidFlag;
    start_next  = packetStartFlag;
    toggle_next = ~toggle_reg;       // one event per byte clock rising edge
    if (rstS2_reg) begin
      data_next   = BYTE_RST;
      valid_next  = 1'b0;
      start_next  = 1'b0;
      toggle_next = 1'b0;
    end
  end

  always_ff @(posedge byteClk) begin
    data_reg   <= data_next;
    valid_reg  <= valid_next;
    start_reg  <= start_next;
    toggle_reg <= toggle_next;
  end

  assign xfer.data             = data_reg;
  assign xfer.payloadValidFlag = valid_reg;
  assign xfer.packetStartFlag  = start_reg;
  assign xfer.toggle           = toggle_reg;
endmodule

// file: hw/tspl_link_top.sv
// transport-stream synchronous serial link: transmitter and receiver
`timescale 1ns/100ps
module tspl_link_top #(
  parameter int SYNC_MISSES = tspl_pkg::SYNC_MISS_LIMIT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       byteClk,
  input  wire logic [7:0] txByte,
  input  wire logic       txPayloadValidFlag,
  input  wire logic       txPacketStartFlag,
  input  wire logic       mode204,
  output logic            txFormatError,
  output logic            serialOut,
  input  wire logic       serialIn,
  output logic [7:0]      rxByte,
  output logic            rxPayloadValidFlag,
  output logic            rxPacketStartFlag,
  output logic            rxByteStrobe,
  output logic            rxAligned
);
  import tspl_pkg::*;

  tspl_xfer_if xfer ();

  // eleven lines in, one serial line out, one line in
  tspl_byte_capture u_cap (
    .byteClk          (byteClk),
    .rst              (rst),
    .byteIn           (txByte),
    .payloadValidFlag (txPayloadValidFlag),
    .packetStartFlag  (txPacketStartFlag),
    .xfer             (xfer)
  );

  function automatic logic [7:0] pktLast(input logic long);
    pktLast = long ? 8'(PKT_LEN_LONG - 1) : 8'(PKT_LEN_SHORT - 1);
  endfunction

  // pin synchronisers
  logic tgS1_reg;
  logic tgS2_reg;
  logic tgS3_reg;
  logic inS1_reg;
  logic inS2_reg;
  logic mdS1_reg;
  logic mdS2_reg;

  // byte event toggle: two stages plus one for edge detection
  always_ff @(posedge clk) begin
    tgS1_reg <= xfer.toggle;
    tgS2_reg <= tgS1_reg;
    tgS3_reg <= tgS2_reg;
  end

  // serial line input
  always_ff @(posedge clk) begin
    inS1_reg <= serialIn;
    inS2_reg <= inS1_reg;
  end

  // packet length selection pin
  always_ff @(posedge clk) begin
    mdS1_reg <= mode204;
    mdS2_reg <= mdS1_reg;
  end

  // transmit path
  // one half-cell per clock, sixteen half-cells per byte
  logic [7:0] pend_reg;
  logic [7:0] pend_next;
  logic       pendFull_reg;
  logic       pendFull_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] half_reg;
  logic [3:0] half_next;
  logic       line_reg;
  logic       line_next;
  logic       fmtErr_reg;
  logic       fmtErr_next;
  logic       newByte;

  // the toggle stays wide enough up to the byte clock ceiling
  assign newByte = tgS2_reg ^ tgS3_reg;

  always_comb begin
    pend_next     = pend_reg;
    pendFull_next = pendFull_reg;
    shift_next    = shift_reg;
    half_next     = half_reg + 4'h1;
    line_next     = line_reg;
    fmtErr_next   = 1'b0;
    // byte data is held a whole byte period, so it is stable once seen
    if (newByte) begin
      pend_next     = xfer.data;
      pendFull_next = 1'b1;
      fmtErr_next   = xfer.packetStartFlag &&
                      (xfer.data != SYNC_BYTE || !xfer.payloadValidFlag);
    end
    // boundary toggle always, mid-cell toggle for a one
    if (!half_reg[0]) begin
      line_next = ~line_reg;
    end else if (shift_reg[7]) begin
      line_next = ~line_reg;
    end
    if (half_reg[0]) begin
      shift_next = {shift_reg[6:0], 1'b0}; // msb first
    end
    // one byte per 16 half-cells, no stuffing
    if (half_reg == 4'(HALF_PER_BYTE - 1)) begin
      // gap bytes are sent like any other byte
      shift_next = pendFull_next ? pend_next : BYTE_RST;
      pendFull_next = 1'b0;
    end
    if (rst) begin
      pend_next     = BYTE_RST;
      pendFull_next = 1'b0;
      shift_next    = BYTE_RST;
      half_next     = 4'h0;
      line_next     = LINE_RST;
      fmtErr_next   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    pend_reg     <= pend_next;
    pendFull_reg <= pendFull_next;
    shift_reg    <= shift_next;
    half_reg     <= half_next;
    line_reg     <= line_next;
    fmtErr_reg   <= fmtErr_next;
  end

  assign serialOut     = line_reg;
  assign txFormatError = fmtErr_reg;

  // Biphase Mark decoder
  // phase 0 expects the cell boundary edge, phase 1 reads the mid cell
  logic lvl_reg;
  logic lvl_next;
  logic first_reg;
  logic first_next;
  logic phase_reg;
  logic phase_next;
  logic bitVal_reg;
  logic bitVal_next;
  logic bitStb_reg;
  logic bitStb_next;
  logic lineSlip;

  // no boundary edge where one is due: cell phase or line is lost
  assign lineSlip = !phase_reg && (inS2_reg == lvl_reg);

  always_comb begin
    lvl_next    = inS2_reg;
    first_next  = first_reg;
    phase_next  = phase_reg;
    bitVal_next = bitVal_reg;
    bitStb_next = 1'b0;
    if (!phase_reg) begin
      // a missing boundary edge means the cell phase slipped: hold phase
      if (inS2_reg != lvl_reg) begin
        first_next = inS2_reg;
        phase_next = 1'b1;
      end
    end else begin
      bitVal_next = inS2_reg != first_reg; // mid edge is a one
      bitStb_next = 1'b1;
      phase_next  = 1'b0;
    end
    if (rst) begin
      lvl_next    = LINE_RST;
      first_next  = LINE_RST;
      phase_next  = 1'b0;
      bitVal_next = 1'b0;
      bitStb_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    lvl_reg    <= lvl_next;
    first_reg  <= first_next;
    phase_reg  <= phase_next;
    bitVal_reg <= bitVal_next;
    bitStb_reg <= bitStb_next;
  end

  // sync hunt, confirmation one packet later, then byte alignment
  tspl_align_t state_reg;
  tspl_align_t state_next;
  logic [7:0]  rxSh_reg;
  logic [7:0]  rxSh_next;
  logic [2:0]  bitCnt_reg;
  logic [2:0]  bitCnt_next;
  logic [7:0]  byteCnt_reg;
  logic [7:0]  byteCnt_next;
  logic [1:0]  miss_reg;
  logic [1:0]  miss_next;
  logic [7:0]  rxByte_reg;
  logic [7:0]  rxByte_next;
  logic        rxVal_reg;
  logic        rxVal_next;
  logic        rxStart_reg;
  logic        rxStart_next;
  logic        rxStb_reg;
  logic        rxStb_next;
  logic [7:0]  shIn;
  logic        byteDone;
  logic        atSync;
  logic        gapByte;

  assign shIn     = {rxSh_reg[6:0], bitVal_reg};
  assign byteDone = bitStb_reg && (bitCnt_reg == 3'(BITS_PER_BYTE - 1));
  assign atSync   = byteCnt_reg == pktLast(mdS2_reg);
  // filler bytes of a long packet; the next sync byte is not one of them
  assign gapByte  = mdS2_reg && !atSync &&
                    byteCnt_reg >= 8'(PKT_LEN_SHORT - 1);

  always_comb begin
    state_next   = state_reg;
    rxSh_next    = rxSh_reg;
    bitCnt_next  = bitCnt_reg;
    byteCnt_next = byteCnt_reg;
    miss_next    = miss_reg;
    rxByte_next  = rxByte_reg;
    rxVal_next   = rxVal_reg;
    rxStart_next = rxStart_reg;
    rxStb_next   = 1'b0;
    if (bitStb_reg) begin
      rxSh_next   = shIn;
      bitCnt_next = bitCnt_reg + 3'h1;
    end
    case (state_reg)
      TSPL_HUNT: begin
        // sync word found at any bit position fixes the boundary
        if (bitStb_reg && shIn == SYNC_BYTE) begin
          state_next   = TSPL_CONFIRM;
          bitCnt_next  = 3'h0;
          byteCnt_next = 8'h00;
        end
      end
      TSPL_CONFIRM, TSPL_LOCKED: begin
        // a lost cell boundary drops alignment at once
        if (lineSlip) begin
          state_next = TSPL_HUNT;
        end else if (byteDone) begin
          byteCnt_next = atSync ? 8'h00 : byteCnt_reg + 8'h01;
          if (atSync && shIn == SYNC_BYTE) begin
            state_next = TSPL_LOCKED;
            miss_next  = 2'h0;
          end else if (atSync && state_reg == TSPL_CONFIRM) begin
            state_next = TSPL_HUNT;
          end else if (atSync) begin
            miss_next = miss_reg + 2'h1;
            if (miss_next == 2'(SYNC_MISSES)) begin
              state_next = TSPL_HUNT;
            end
          end
          // bytes go out only once aligned
          if (state_next == TSPL_LOCKED) begin
            rxByte_next  = shIn;
            rxStart_next = atSync;
            rxVal_next   = !gapByte;
            rxStb_next   = 1'b1;
          end
        end
      end
      default: state_next = TSPL_HUNT;
    endcase
    if (rst) begin
      state_next   = TSPL_HUNT;
      rxSh_next    = BYTE_RST;
      bitCnt_next  = 3'h0;
      byteCnt_next = 8'h00;
      miss_next    = 2'h0;
      rxByte_next  = BYTE_RST;
      rxVal_next   = 1'b0;
      rxStart_next = 1'b0;
      rxStb_next   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_reg   <= state_next;
    rxSh_reg    <= rxSh_next;
    bitCnt_reg  <= bitCnt_next;
    byteCnt_reg <= byteCnt_next;
    miss_reg    <= miss_next;
    rxByte_reg  <= rxByte_next;
    rxVal_reg   <= rxVal_next;
    rxStart_reg <= rxStart_next;
    rxStb_reg   <= rxStb_next;
  end

  assign rxByte             = rxByte_reg;
  assign rxPayloadValidFlag = rxVal_reg;
  assign rxPacketStartFlag  = rxStart_reg;
  assign rxByteStrobe       = rxStb_reg;
  assign rxAligned          = state_reg == TSPL_LOCKED;

endmodule

// file: sim/tspl_link_asserts.sv
// port assertions for the transport-stream link top
`timescale 1ns/100ps
module tspl_link_asserts #(
  parameter int SYNC_MISSES = tspl_pkg::SYNC_MISS_LIMIT
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       mode204,
  input wire logic       txFormatError,
  input wire logic       serialOut,
  input wire logic [7:0] rxByte,
  input wire logic       rxPayloadValidFlag,
  input wire logic       rxPacketStartFlag,
  input wire logic       rxByteStrobe,
  input wire logic       rxAligned
);
  import tspl_pkg::*;
  // cycles since reset, saturating, so the line check skips start-up
  logic [5:0] run_reg;
  logic [5:0] run_next;
  always_comb run_next = (run_reg == 6'h3f) ? run_reg : run_reg + 6'h01;
  always_ff @(posedge clk) run_reg <= rst ? 6'h00 : run_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_pulse; rxByteStrobe |=> !rxByteStrobe[*8]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe too close");
  property p_cadence;
    rxByteStrobe |-> ##16 (rxByteStrobe || !rxAligned);
  endproperty
  a_cadence: assert property (p_cadence)
    else $error("byte cadence broken");
  property p_locked; rxByteStrobe |-> rxAligned; endproperty
  a_locked: assert property (p_locked)
    else $error("byte out while not aligned");
  property p_first;
    $rose(rxAligned) |->
      ##[0:20] (rxByteStrobe && rxPacketStartFlag && rxByte == SYNC_BYTE);
  endproperty
  a_first: assert property (p_first)
    else $error("first byte after lock not sync");
  property p_start;
    rxByteStrobe && rxPacketStartFlag |-> rxPayloadValidFlag;
  endproperty
  a_start: assert property (p_start)
    else $error("start byte not valid");
  property p_hold; !rxByteStrobe |-> $stable(rxByte); endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed without strobe");
  property p_valid188;
    rxByteStrobe && !mode204 |-> rxPayloadValidFlag;
  endproperty
  a_valid188: assert property (p_valid188)
    else $error("valid low in short mode");
  property p_err; txFormatError |=> !txFormatError; endproperty
  a_err: assert property (p_err)
    else $error("format error not a pulse");
  property p_toggle;
    run_reg == 6'h3f && $stable(serialOut) |=> $changed(serialOut);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("line flat for three half cells");
endmodule

bind tspl_link_top tspl_link_asserts #(.SYNC_MISSES(SYNC_MISSES))
  u_tspl_link_asserts (.clk, .rst, .mode204, .txFormatError, .serialOut,
  .rxByte, .rxPayloadValidFlag, .rxPacketStartFlag, .rxByteStrobe,
  .rxAligned);

// file: sim/tspl_ts_source.sv
// transport packet source for the parallel transmit port
`timescale 1ns/100ps
module tspl_ts_source (
  input  wire logic       byteClk,
  input  wire logic       rst,
  input  wire logic       mode204,
  input  wire logic       badSync,
  output logic [7:0]      byteOut,
  output logic            validOut,
  output logic            startOut
);
  import tspl_pkg::*;
  int idx;
  int wake;
  initial {byteOut, validOut, startOut} = 10'h000;
  // payload never holds three ones in a row, so no false sync
  always @(posedge byteClk) begin
    if (rst) begin
      {idx, wake} <= '0;
      {byteOut, validOut, startOut} <= 10'h000;
    end else if (wake < 4) begin
      wake <= wake + 1;
    end else begin
      idx <= (idx == (mode204 ? PKT_LEN_LONG : PKT_LEN_SHORT) - 1) ? 0 :
             idx + 1;
      startOut <= (idx == 0);
      validOut <= !(mode204 && idx >= PKT_LEN_SHORT);
      if (idx == 0) byteOut <= badSync ? 8'h46 : SYNC_BYTE;
      else if (mode204 && idx >= PKT_LEN_SHORT) byteOut <= 8'h00;
      else byteOut <= 8'(32'ha512_8001 >> (8 * (idx % 4)));
    end
  end
endmodule

// file: sim/tspl_link_top_tb.sv
// self-checking bench for the transport-stream link top
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tspl_link_top_tb;
  import tspl_pkg::*;
  logic       clk, rst, byteClk, mode204, badSync, lineCut, serialIn;
  logic [7:0] txByte, rxByte;
  logic       txPayloadValidFlag, txPacketStartFlag, txFormatError;
  logic       serialOut, rxPayloadValidFlag, rxPacketStartFlag;
  logic       rxByteStrobe, rxAligned;
  int         fails, comparisons;
  assign serialIn = lineCut ? 1'b1 : serialOut;
  tspl_link_top #(.SYNC_MISSES(2)) u_tspl_link_top (.clk, .rst, .byteClk,
    .txByte, .txPayloadValidFlag, .txPacketStartFlag, .mode204,
    .txFormatError, .serialOut, .serialIn, .rxByte, .rxPayloadValidFlag,
    .rxPacketStartFlag, .rxByteStrobe, .rxAligned);
  tspl_ts_source u_tspl_ts_source (.byteClk, .rst, .mode204, .badSync,
    .byteOut(txByte), .validOut(txPayloadValidFlag),
    .startOut(txPacketStartFlag));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // 6.25 MHz byte clock, 16 system clocks per byte
  initial begin
    byteClk = 1'b0;
    #3;
    forever #80 byteClk = ~byteClk;
  end
  task automatic final_report;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic guard(input bit ok);
    if (!ok) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      final_report();
    end
  endtask
  task automatic wait_strobe(input int lim);
    int n;
    @(negedge clk);
    for (n = 0; n < lim && !rxByteStrobe; n++) @(negedge clk);
    guard(rxByteStrobe);
  endtask
  task automatic run_mode(input logic m);
    int i, k, len;
    len = m ? PKT_LEN_LONG : PKT_LEN_SHORT;
    @(posedge clk);
    rst <= 1'b1;
    mode204 <= m;
    repeat (50) @(negedge clk);
    `CHK({rxAligned, rxByteStrobe, serialOut, txFormatError}, 4'h0)
    @(posedge clk);
    rst <= 1'b0;
    wait_strobe(20000);
    for (i = 0; i <= len; i++) begin
      k = i % len;
      if (i > 0) wait_strobe(40);
      if (k == 0) `CHK(rxByte, SYNC_BYTE)
      else if (m && k >= PKT_LEN_SHORT) `CHK(rxByte, 8'h00)
      else `CHK(rxByte, 8'(32'ha512_8001 >> (8 * (k % 4))))
      `CHK(rxPacketStartFlag, k == 0)
      `CHK(rxPayloadValidFlag, !(m && k >= PKT_LEN_SHORT))
    end
    $display("test mode %0d done", m);
  endtask
  task automatic test_bad_sync;
    int n;
    @(posedge clk);
    badSync <= 1'b1;
    for (n = 0; n < 8000 && txFormatError !== 1'b1; n++) @(negedge clk);
    `CHK(txFormatError, 1'b1)
    @(posedge clk);
    badSync <= 1'b0;
    $display("test bad sync done");
  endtask
  task automatic test_loss;
    int n;
    @(posedge clk);
    lineCut <= 1'b1;
    for (n = 0; n < 20000 && rxAligned; n++) @(negedge clk);
    `CHK(rxAligned, 1'b0)
    @(posedge clk);
    lineCut <= 1'b0;
    for (n = 0; n < 20000 && !rxAligned; n++) @(negedge clk);
    `CHK(rxAligned, 1'b1)
    $display("test loss done");
  endtask
  initial begin
    {rst, mode204, badSync, lineCut} = 4'h8;
    fails = 0;
    comparisons = 0;
    run_mode(1'b0);
    run_mode(1'b1);
    test_bad_sync();
    test_loss();
    final_report();
  end
endmodule
